// ### include/tmo_pkg.sv
// tmo_pkg: register map, field layout and encodings of the timer option and irq enable block
package tmo_pkg;

  localparam int unsigned TMO_NUM_TIMERS = 2;
  localparam int unsigned TMO_NUM_CH     = 4;
  localparam int unsigned TMO_EVT_W      = 7;
  localparam int unsigned TMO_OPT_W      = 8;

  // apb byte addresses
  localparam logic [31:0] TMO_ADDR_T1_FLAG   = 32'h4000a800;
  localparam logic [31:0] TMO_ADDR_T2_FLAG   = 32'h4000a804;
  localparam logic [31:0] TMO_ADDR_T1_MISS   = 32'h4000a818;
  localparam logic [31:0] TMO_ADDR_T2_MISS   = 32'h4000a81c;
  localparam logic [31:0] TMO_ADDR_T1_IRQ_EN = 32'h4000a840;
  localparam logic [31:0] TMO_ADDR_T2_IRQ_EN = 32'h4000a844;
  localparam logic [31:0] TMO_ADDR_T1_CLR    = 32'h4000a860;
  localparam logic [31:0] TMO_ADDR_T2_CLR    = 32'h4000a864;
  localparam logic [31:0] TMO_ADDR_T1_OPT    = 32'h4000e050;
  localparam logic [31:0] TMO_ADDR_T2_OPT    = 32'h4000f050;

  // option register fields
  localparam int unsigned TMO_OPT_TRIG_LSB  = 0;
  localparam int unsigned TMO_OPT_TRIG_MSB  = 1;
  localparam int unsigned TMO_OPT_MASK_BIT  = 2;
  localparam int unsigned TMO_OPT_RSVD_BIT  = 3;
  localparam int unsigned TMO_OPT_REMAP_LSB = 4;
  localparam int unsigned TMO_OPT_REMAP_MSB = 7;
  localparam logic [7:0]  TMO_OPT1_WMASK    = 8'h0f;
  localparam logic [7:0]  TMO_OPT2_WMASK    = 8'hff;
  localparam logic [7:0]  TMO_OPT_RST       = 8'h00;

  // event / enable / flag layout: update 0, cc1..cc4 1..4, trigger 6
  localparam int unsigned TMO_EVT_UPD_BIT  = 0;
  localparam int unsigned TMO_EVT_CC_LSB   = 1;
  localparam int unsigned TMO_EVT_CC_MSB   = 4;
  localparam int unsigned TMO_EVT_TRIG_BIT = 6;
  localparam logic [6:0]  TMO_EVT_MASK     = 7'h5f;
  localparam logic [6:0]  TMO_EVT_RST      = 7'h00;

  // missed register: cc1..cc4 at bits 9..12
  localparam int unsigned TMO_MISS_LSB = 9;
  localparam int unsigned TMO_MISS_MSB = 12;
  localparam logic [3:0]  TMO_MISS_RST = 4'h0;

  // port a pin index used by each channel when not remapped; port b pin n+1 for channel n
  localparam int unsigned TMO_CH_PA_IDX [4] = '{0, 3, 1, 2};

  typedef enum logic [1:0] {
    TMO_TRIG_BUS   = 2'h0,
    TMO_TRIG_1KHZ  = 2'h1,
    TMO_TRIG_32KHZ = 2'h2,
    TMO_TRIG_PIN   = 2'h3
  } tmo_trig_sel_t;

endpackage : tmo_pkg

// ### verilog/tmo_trig_sel.sv
// tmo_trig_sel: external trigger source selection and clock pin masking for one timer
`timescale 1ns/1ns
`default_nettype none
module tmo_trig_sel
  import tmo_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  input  wire tmo_pkg::tmo_trig_sel_t i_sel,
  input  wire logic                   i_mask_en,
  input  wire logic                   i_bus_clock,
  input  wire logic                   i_cal_1khz,
  input  wire logic                   i_ref_32khz,
  input  wire logic                   i_ext_clock_pin,
  input  wire logic                   i_clock_mask_input,
  output logic                        o_trigger
);
  import tmo_pkg::*;

  logic pin_gated;
  logic trig_d;
  logic trig_q;

  // mask input only matters while the pin is the chosen source
  assign pin_gated = i_mask_en ? (i_ext_clock_pin & i_clock_mask_input) : i_ext_clock_pin;

  assign trig_d = (i_sel == TMO_TRIG_BUS)   ? i_bus_clock :
                  (i_sel == TMO_TRIG_1KHZ)  ? i_cal_1khz  :
                  (i_sel == TMO_TRIG_32KHZ) ? i_ref_32khz :
                                              pin_gated;

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      trig_q <= 1'b0;
    else
      trig_q <= trig_d;
  end

  assign o_trigger = trig_q;

endmodule : tmo_trig_sel
`default_nettype wire

// ### verilog/tmo_pin_remap.sv
// tmo_pin_remap: steers the second timer's four channels between port a and port b pins
`timescale 1ns/1ns
`default_nettype none
module tmo_pin_remap
  import tmo_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_nrst,
  input  wire logic [3:0] i_remap,
  input  wire logic [3:0] i_ch_out,
  input  wire logic [3:0] i_ch_oe,
  output logic      [3:0] o_ch_in,
  input  wire logic [3:0] i_pa_in,
  output logic      [3:0] o_pa_out,
  output logic      [3:0] o_pa_oe,
  input  wire logic [3:0] i_pb_in,
  output logic      [3:0] o_pb_out,
  output logic      [3:0] o_pb_oe
);
  import tmo_pkg::*;

  logic [3:0] pa_out_d, pa_oe_d, pb_out_d, pb_oe_d, ch_in_d;
  logic [3:0] pa_out_q, pa_oe_q, pb_out_q, pb_oe_q, ch_in_q;

  // a pin not selected for its channel is released (oe low, out low)
  for (genvar c = 0; c < TMO_NUM_CH; c++)
  begin : g_ch
    assign pa_out_d[TMO_CH_PA_IDX[c]] = i_ch_out[c] & ~i_remap[c];
    assign pa_oe_d[TMO_CH_PA_IDX[c]]  = i_ch_oe[c] & ~i_remap[c];
    assign pb_out_d[c]                = i_ch_out[c] & i_remap[c];
    assign pb_oe_d[c]                 = i_ch_oe[c] & i_remap[c];
    assign ch_in_d[c] = i_remap[c] ? i_pb_in[c] : i_pa_in[TMO_CH_PA_IDX[c]];
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pa_out_q <= 4'h0;
      pa_oe_q  <= 4'h0;
      pb_out_q <= 4'h0;
      pb_oe_q  <= 4'h0;
      ch_in_q  <= 4'h0;
    end
    else
    begin
      pa_out_q <= pa_out_d;
      pa_oe_q  <= pa_oe_d;
      pb_out_q <= pb_out_d;
      pb_oe_q  <= pb_oe_d;
      ch_in_q  <= ch_in_d;
    end
  end

  assign o_pa_out = pa_out_q;
  assign o_pa_oe  = pa_oe_q;
  assign o_pb_out = pb_out_q;
  assign o_pb_oe  = pb_oe_q;
  assign o_ch_in  = ch_in_q;

endmodule : tmo_pin_remap
`default_nettype wire

// ### verilog/tmo_timer_cfg.sv
// tmo_timer_cfg: apb register block for timer options, trigger selection and interrupts
//
// Function
// - mask enable ands pin with mask input
// - two-bit field picks external clock-2 trigger
// - trigger codes: bus, 1khz, 32khz, pin
// - bit seven moves channel4 pa2 to pb4
// - bit six moves channel3 pa1 to pb3
// - bit five moves channel2 pa3 to pb2
// - bit four moves channel1 pa0 to pb1
// - enable bits: update, cc1-4, trigger only
// - option and enable registers reset zero
// - flag register holds pending events, same layout
// - missed bits record repeated cc events
`timescale 1ns/1ns
`default_nettype none
module tmo_timer_cfg
  import tmo_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // timer event pulses, bit layout as the flag register
  input  wire logic [6:0]  i_tim1_events,
  input  wire logic [6:0]  i_tim2_events,
  // trigger sources
  input  wire logic        i_bus_clock,
  input  wire logic        i_cal_1khz,
  input  wire logic        i_ref_32khz,
  input  wire logic        i_timer1_ext_clock_pin,
  input  wire logic        i_timer2_ext_clock_pin,
  input  wire logic        i_timer1_clock_mask_input,
  input  wire logic        i_timer2_clock_mask_input,
  output logic             o_tim1_trigger,
  output logic             o_tim2_trigger,
  // second timer channel routing
  input  wire logic [3:0]  i_tim2_ch_out,
  input  wire logic [3:0]  i_tim2_ch_oe,
  output logic      [3:0]  o_tim2_ch_in,
  input  wire logic [3:0]  i_porta_in,
  output logic      [3:0]  o_porta_out,
  output logic      [3:0]  o_porta_oe,
  input  wire logic [3:0]  i_portb_in,
  output logic      [3:0]  o_portb_out,
  output logic      [3:0]  o_portb_oe,
  // interrupts
  output logic             o_tim1_irq,
  output logic             o_tim2_irq,
  output logic             o_irq
);
  import tmo_pkg::*;

  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] r);
    return a == r;
  endfunction : addr_hit

  function automatic logic [31:0] widen_evt(input logic [6:0] v);
    return {25'h0, v};
  endfunction : widen_evt

  function automatic logic [31:0] widen_miss(input logic [3:0] v);
    return 32'(v) << TMO_MISS_LSB;
  endfunction : widen_miss

  // a new event in the clearing cycle keeps its flag set
  function automatic logic [6:0] flag_next(input logic [6:0] q,
                                           input logic [6:0] clr,
                                           input logic [6:0] ev);
    return (q & ~clr) | ev;
  endfunction : flag_next

  // a cc event that finds its flag already pending is recorded as missed
  function automatic logic [3:0] miss_next(input logic [3:0] q,
                                           input logic [3:0] clr,
                                           input logic [6:0] ev,
                                           input logic [6:0] flag);
    return (q & ~clr) |
           (ev[TMO_EVT_CC_MSB:TMO_EVT_CC_LSB] & flag[TMO_EVT_CC_MSB:TMO_EVT_CC_LSB]);
  endfunction : miss_next

  // apb phase decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign apb_wr     = apb_access & i_pwrite;

  // address decode
  logic hit_flag1, hit_flag2, hit_miss1, hit_miss2;
  logic hit_en1, hit_en2, hit_clr1, hit_clr2;
  logic hit_opt1, hit_opt2, hit_any;
  assign hit_flag1 = addr_hit(i_paddr, TMO_ADDR_T1_FLAG);
  assign hit_flag2 = addr_hit(i_paddr, TMO_ADDR_T2_FLAG);
  assign hit_miss1 = addr_hit(i_paddr, TMO_ADDR_T1_MISS);
  assign hit_miss2 = addr_hit(i_paddr, TMO_ADDR_T2_MISS);
  assign hit_en1   = addr_hit(i_paddr, TMO_ADDR_T1_IRQ_EN);
  assign hit_en2   = addr_hit(i_paddr, TMO_ADDR_T2_IRQ_EN);
  assign hit_clr1  = addr_hit(i_paddr, TMO_ADDR_T1_CLR);
  assign hit_clr2  = addr_hit(i_paddr, TMO_ADDR_T2_CLR);
  assign hit_opt1  = addr_hit(i_paddr, TMO_ADDR_T1_OPT);
  assign hit_opt2  = addr_hit(i_paddr, TMO_ADDR_T2_OPT);
  assign hit_any   = hit_flag1 | hit_flag2 | hit_miss1 | hit_miss2 | hit_en1 | hit_en2 |
                     hit_clr1 | hit_clr2 | hit_opt1 | hit_opt2;

  // register state
  logic [7:0] opt1_q, opt1_d;
  logic [7:0] opt2_q, opt2_d;
  logic [6:0] en1_q, en1_d;
  logic [6:0] en2_q, en2_d;
  logic [6:0] flag1_q, flag1_d;
  logic [6:0] flag2_q, flag2_d;
  logic [3:0] miss1_q, miss1_d;
  logic [3:0] miss2_q, miss2_d;

  // option registers; the reserved bit is stored as written, software keeps it at zero
  assign opt1_d = (apb_wr && hit_opt1) ? (i_pwdata[7:0] & TMO_OPT1_WMASK) : opt1_q;
  assign opt2_d = (apb_wr && hit_opt2) ? (i_pwdata[7:0] & TMO_OPT2_WMASK) : opt2_q;

  // enable registers: only documented enable bits are writable
  assign en1_d = (apb_wr && hit_en1) ? (i_pwdata[6:0] & TMO_EVT_MASK) : en1_q;
  assign en2_d = (apb_wr && hit_en2) ? (i_pwdata[6:0] & TMO_EVT_MASK) : en2_q;

  // write-one-to-clear strobes
  logic [6:0] flag1_clr, flag2_clr;
  logic [3:0] miss1_clr, miss2_clr;
  assign flag1_clr = (apb_wr && hit_clr1) ? i_pwdata[6:0] : TMO_EVT_RST;
  assign flag2_clr = (apb_wr && hit_clr2) ? i_pwdata[6:0] : TMO_EVT_RST;
  assign miss1_clr = (apb_wr && hit_miss1) ? i_pwdata[TMO_MISS_MSB:TMO_MISS_LSB] : TMO_MISS_RST;
  assign miss2_clr = (apb_wr && hit_miss2) ? i_pwdata[TMO_MISS_MSB:TMO_MISS_LSB] : TMO_MISS_RST;

  // events restricted to the documented positions
  logic [6:0] ev1, ev2;
  assign ev1 = i_tim1_events & TMO_EVT_MASK;
  assign ev2 = i_tim2_events & TMO_EVT_MASK;

  assign flag1_d = flag_next(flag1_q, flag1_clr, ev1);
  assign flag2_d = flag_next(flag2_q, flag2_clr, ev2);

  assign miss1_d = miss_next(miss1_q, miss1_clr, ev1, flag1_q);
  assign miss2_d = miss_next(miss2_q, miss2_clr, ev2, flag2_q);

  // one short process per register keeps each reset value beside its storage
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      opt1_q <= TMO_OPT_RST;
    else
      opt1_q <= opt1_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      opt2_q <= TMO_OPT_RST;
    else
      opt2_q <= opt2_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      en1_q <= TMO_EVT_RST;
    else
      en1_q <= en1_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      en2_q <= TMO_EVT_RST;
    else
      en2_q <= en2_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      flag1_q <= TMO_EVT_RST;
    else
      flag1_q <= flag1_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      flag2_q <= TMO_EVT_RST;
    else
      flag2_q <= flag2_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      miss1_q <= TMO_MISS_RST;
    else
      miss1_q <= miss1_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      miss2_q <= TMO_MISS_RST;
    else
      miss2_q <= miss2_d;
  end

  // read selection; clear register reads as zero
  logic [31:0] rd_mux;
  assign rd_mux = hit_flag1 ? widen_evt(flag1_q) :
                  hit_flag2 ? widen_evt(flag2_q) :
                  hit_miss1 ? widen_miss(miss1_q) :
                  hit_miss2 ? widen_miss(miss2_q) :
                  hit_en1   ? widen_evt(en1_q) :
                  hit_en2   ? widen_evt(en2_q) :
                  hit_opt1  ? {24'h0, opt1_q} :
                  hit_opt2  ? {24'h0, opt2_q} :
                              32'h0;

  // read data and error are captured in the setup cycle, so read data leaves a flip-flop and the error one gated by apb_access;
  // the cost is that a read shows state as of the setup edge
  logic [31:0] prdata_q;
  logic        slverr_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      prdata_q <= 32'h0;
    else if (apb_setup)
      prdata_q <= rd_mux;
  end

  // an unmapped address is known at setup, so the error is ready for the access edge
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      slverr_q <= 1'b0;
    else if (apb_setup)
      slverr_q <= ~hit_any;
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = slverr_q & apb_access;

  // trigger selection per timer
  tmo_trig_sel u_trig1 (
    .i_ref_clk          (i_ref_clk),
    .i_nrst             (i_nrst),
    .i_sel              (tmo_trig_sel_t'(opt1_q[TMO_OPT_TRIG_MSB:TMO_OPT_TRIG_LSB])),
    .i_mask_en          (opt1_q[TMO_OPT_MASK_BIT]),
    .i_bus_clock        (i_bus_clock),
    .i_cal_1khz         (i_cal_1khz),
    .i_ref_32khz        (i_ref_32khz),
    .i_ext_clock_pin    (i_timer1_ext_clock_pin),
    .i_clock_mask_input (i_timer1_clock_mask_input),
    .o_trigger          (o_tim1_trigger)
  );

  tmo_trig_sel u_trig2 (
    .i_ref_clk          (i_ref_clk),
    .i_nrst             (i_nrst),
    .i_sel              (tmo_trig_sel_t'(opt2_q[TMO_OPT_TRIG_MSB:TMO_OPT_TRIG_LSB])),
    .i_mask_en          (opt2_q[TMO_OPT_MASK_BIT]),
    .i_bus_clock        (i_bus_clock),
    .i_cal_1khz         (i_cal_1khz),
    .i_ref_32khz        (i_ref_32khz),
    .i_ext_clock_pin    (i_timer2_ext_clock_pin),
    .i_clock_mask_input (i_timer2_clock_mask_input),
    .o_trigger          (o_tim2_trigger)
  );

  // channel pins of the second timer
  tmo_pin_remap u_remap (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_remap   (opt2_q[TMO_OPT_REMAP_MSB:TMO_OPT_REMAP_LSB]),
    .i_ch_out  (i_tim2_ch_out),
    .i_ch_oe   (i_tim2_ch_oe),
    .o_ch_in   (o_tim2_ch_in),
    .i_pa_in   (i_porta_in),
    .o_pa_out  (o_porta_out),
    .o_pa_oe   (o_porta_oe),
    .i_pb_in   (i_portb_in),
    .o_pb_out  (o_portb_out),
    .o_pb_oe   (o_portb_oe)
  );

  // interrupt requests are levels straight from flag and enable flip-flops
  assign o_tim1_irq = |(flag1_q & en1_q);
  assign o_tim2_irq = |(flag2_q & en2_q);
  assign o_irq      = o_tim1_irq | o_tim2_irq;

endmodule : tmo_timer_cfg
`default_nettype wire

// ### bench/tmo_timer_cfg_chk.sv
// tmo_timer_cfg_chk: port-level assertions for the timer option and irq block
`timescale 1ns/1ns
`default_nettype none
module tmo_timer_cfg_chk
  import tmo_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [6:0]  i_tim1_events,
  input wire logic        i_bus_clock,
  input wire logic        i_cal_1khz,
  input wire logic        i_ref_32khz,
  input wire logic        i_timer1_ext_clock_pin,
  input wire logic        i_timer2_ext_clock_pin,
  input wire logic        i_timer1_clock_mask_input,
  input wire logic        i_timer2_clock_mask_input,
  input wire logic        o_tim1_trigger,
  input wire logic        o_tim2_trigger,
  input wire logic [3:0]  i_tim2_ch_out,
  input wire logic [3:0]  i_tim2_ch_oe,
  input wire logic [3:0]  o_porta_out,
  input wire logic [3:0]  o_porta_oe,
  input wire logic [3:0]  o_portb_out,
  input wire logic [3:0]  o_portb_oe,
  input wire logic        o_tim1_irq,
  input wire logic        o_tim2_irq,
  input wire logic        o_irq
);
  // shadow copies of the registers, updated on the same access edge as the design
  logic [7:0] o1_q, o2_q;
  logic [6:0] e1_q;
  wire       wr   = i_psel & i_penable & i_pwrite;
  wire [7:0] o1_d = (wr && i_paddr == TMO_ADDR_T1_OPT) ? i_pwdata[7:0] & TMO_OPT1_WMASK : o1_q;
  wire [7:0] o2_d = (wr && i_paddr == TMO_ADDR_T2_OPT) ? i_pwdata[7:0] & TMO_OPT2_WMASK : o2_q;
  wire [6:0] e1_d = (wr && i_paddr == TMO_ADDR_T1_IRQ_EN) ? i_pwdata[6:0] & TMO_EVT_MASK : e1_q;
  wire t1 = o1_q[1] ? (o1_q[0] ? i_timer1_ext_clock_pin & (~o1_q[2] | i_timer1_clock_mask_input)
                                : i_ref_32khz) : (o1_q[0] ? i_cal_1khz : i_bus_clock);
  wire t2 = o2_q[1] ? (o2_q[0] ? i_timer2_ext_clock_pin & (~o2_q[2] | i_timer2_clock_mask_input)
                                : i_ref_32khz) : (o2_q[0] ? i_cal_1khz : i_bus_clock);
  wire [3:0] r    = o2_q[7:4];
  wire [3:0] pad  = ~r & i_tim2_ch_out;
  wire [3:0] pae  = ~r & i_tim2_ch_oe;
  wire [3:0] pa_o = {pad[1], pad[3], pad[2], pad[0]};
  wire [3:0] pa_e = {pae[1], pae[3], pae[2], pae[0]};
  always_ff @(posedge i_ref_clk or negedge i_nrst)
    if (!i_nrst)
      {o1_q, o2_q, e1_q} <= '0;
    else
      {o1_q, o2_q, e1_q} <= {o1_d, o2_d, e1_d};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  AST_TRIG1: assert property ($past(i_nrst) |-> o_tim1_trigger == $past(t1))
    else $error("timer1 trigger is not the selected source");
  AST_TRIG2: assert property ($past(i_nrst) |-> o_tim2_trigger == $past(t2))
    else $error("timer2 trigger is not the selected source");
  AST_MASK: assert property (o1_q[2:0] == 3'h7 && !i_timer1_clock_mask_input |=> !o_tim1_trigger)
    else $error("masked timer1 clock pin passed through");
  AST_PORTA: assert property ($past(i_nrst) |-> {o_porta_out, o_porta_oe} == $past({pa_o, pa_e}))
    else $error("port a pins do not follow channel routing");
  AST_PORTB: assert property ($past(i_nrst) |-> o_portb_out == $past(r & i_tim2_ch_out))
    else $error("port b pins do not follow channel routing");
  AST_IRQ_SET: assert property (|(i_tim1_events & e1_q) |=> o_tim1_irq)
    else $error("enabled timer1 event raised no interrupt");
  AST_IRQ_OR: assert property (o_irq == (o_tim1_irq | o_tim2_irq))
    else $error("combined interrupt differs from timer interrupts");
  AST_RST: assert property ($rose(i_nrst) |-> !o_tim1_irq && !o_tim1_trigger && o_portb_oe == 4'h0)
    else $error("outputs not quiet after reset");
endmodule : tmo_timer_cfg_chk
bind tmo_timer_cfg tmo_timer_cfg_chk i_chk (.*);
`default_nettype wire

// ### bench/testbench.sv
// testbench: self-checking bench for the timer option and irq block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import tmo_pkg::*;
  localparam logic [31:0] ADR [10] = '{TMO_ADDR_T1_OPT, TMO_ADDR_T2_OPT, TMO_ADDR_T1_IRQ_EN,
    TMO_ADDR_T2_IRQ_EN, TMO_ADDR_T1_FLAG, TMO_ADDR_T2_FLAG, TMO_ADDR_T1_MISS, TMO_ADDR_T2_MISS,
    TMO_ADDR_T1_CLR, TMO_ADDR_T2_CLR};
  localparam int PA [4] = '{0, 3, 1, 2};
  logic        clk, nrst, psel, penable, pwrite;
  logic [31:0] paddr, pwdata;
  logic [6:0]  ev1, ev2, src;
  logic [15:0] pv;
  wire  [31:0] prdata;
  wire         pready, pslverr, trg1, trg2, irq1, irq2, irq;
  wire  [3:0]  ch_in, pa_o, pa_e, pb_o, pb_e;
  int          mismatches, total_checks;
  int          opt [2], en [2], flg [2], mis [2];
  tmo_timer_cfg i_tmo_timer_cfg (
    .i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_tim1_events(ev1), .i_tim2_events(ev2),
    .i_bus_clock(src[0]), .i_cal_1khz(src[1]), .i_ref_32khz(src[2]),
    .i_timer1_ext_clock_pin(src[3]), .i_timer2_ext_clock_pin(src[4]),
    .i_timer1_clock_mask_input(src[5]), .i_timer2_clock_mask_input(src[6]),
    .o_tim1_trigger(trg1), .o_tim2_trigger(trg2), .i_tim2_ch_out(pv[3:0]),
    .i_tim2_ch_oe(pv[7:4]), .o_tim2_ch_in(ch_in), .i_porta_in(pv[11:8]),
    .o_porta_out(pa_o), .o_porta_oe(pa_e), .i_portb_in(pv[15:12]),
    .o_portb_out(pb_o), .o_portb_oe(pb_e), .o_tim1_irq(irq1), .o_tim2_irq(irq2),
    .o_irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // one transfer; pready, read data and error are taken at the rising edge ending access
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic err);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      mismatches++;
      print_verdict();
    end
    `CHK(pslverr, err)
    if (!w)
      `CHK(prdata, x)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  function automatic logic tsel(input int o, input logic [6:0] s, input int t);
    case (o & 3)
      0: return s[0];
      1: return s[1];
      2: return s[2];
      default: return s[3+t] & (((o & 4) == 0) | s[5+t]);
    endcase
  endfunction : tsel
  task automatic pins(input logic [3:0] r);
    logic [3:0] ea, eae, ci;
    for (int c = 0; c < 4; c++)
    begin
      ea[PA[c]]  = ~r[c] & pv[c];
      eae[PA[c]] = ~r[c] & pv[4+c];
      ci[c]      = r[c] ? pv[12+c] : pv[8+PA[c]];
    end
    `CHK({pa_o, pa_e}, {ea, eae})
    `CHK({pb_o, pb_e}, {r & pv[3:0], r & pv[7:4]})
    `CHK(ch_in, ci)
  endtask : pins
  initial
  begin
    int i, t, k;
    logic [31:0] d, x;
    {nrst, psel, penable, pwrite, paddr, pwdata, ev1, ev2, src, pv} = '0;
    mismatches   = 0;
    total_checks = 0;
    k = $urandom(32'heb82411b);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 10; i++)
      bus(1'b0, ADR[i], 0, 0, 1'b0);
    repeat (3)
      for (t = 0; t < 2; t++)
      begin
        d = $urandom & ~32'h8;
        bus(1'b1, ADR[t], d, 0, 1'b0);
        opt[t] = d & (t ? TMO_OPT2_WMASK : TMO_OPT1_WMASK);
        bus(1'b0, ADR[t], 0, opt[t], 1'b0);
        d = $urandom;
        bus(1'b1, ADR[2+t], d, 0, 1'b0);
        bus(1'b0, ADR[2+t], 0, d & 32'h5f, 1'b0);
      end
    // an unmapped word is refused on both directions
    bus(1'b1, 32'h4000a8f0, $urandom, 0, 1'b1);
    bus(1'b0, 32'h4000a8f0, 0, 0, 1'b1);
    for (i = 0; i < 8; i++)
    begin
      for (t = 0; t < 2; t++)
        bus(1'b1, ADR[t], i, 0, 1'b0);
      repeat (4)
      begin
        src <= 7'($urandom);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK({trg1, trg2}, {tsel(i, src, 0), tsel(i, src, 1)})
        @(posedge clk);
      end
    end
    for (i = 0; i < 16; i++)
    begin
      bus(1'b1, ADR[1], i << 4, 0, 1'b0);
      pv <= 16'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      pins(i[3:0]);
    end
    for (i = 0; i < 6; i++)
    begin
      for (t = 0; t < 2; t++)
      begin
        en[t] = (i == 0) ? 0 : $urandom & 32'h5f;
        bus(1'b1, ADR[2+t], en[t], 0, 1'b0);
      end
      d = $urandom;
      x = $urandom;
      // second pulse lands on flags set by the first, so cc repeats count as missed
      {ev2, ev1} <= {d[14:8], d[6:0]};
      @(posedge clk);
      {ev2, ev1} <= {x[14:8], x[6:0]};
      @(posedge clk);
      {ev2, ev1} <= '0;
      for (t = 0; t < 2; t++)
      begin
        k = (d >> (8 * t)) & 32'h5f;
        mis[t] |= (k & flg[t] & 32'h1e) << 8;
        flg[t] |= k;
        k = (x >> (8 * t)) & 32'h5f;
        mis[t] |= (k & flg[t] & 32'h1e) << 8;
        flg[t] |= k;
      end
      @(negedge clk);
      `CHK({irq1, irq2, irq}, {|(flg[0] & en[0]), |(flg[1] & en[1]), |((flg[0] & en[0]) | (flg[1] & en[1]))})
      for (t = 0; t < 2; t++)
      begin
        bus(1'b0, ADR[4+t], 0, flg[t], 1'b0);
        bus(1'b0, ADR[6+t], 0, mis[t], 1'b0);
        d = $urandom;
        bus(1'b1, ADR[8+t], d, 0, 1'b0);
        flg[t] &= ~d;
        bus(1'b0, ADR[4+t], 0, flg[t], 1'b0);
        bus(1'b1, ADR[6+t], d, 0, 1'b0);
        mis[t] &= ~d;
        bus(1'b0, ADR[6+t], 0, mis[t], 1'b0);
      end
    end
    // a reset in mid-run must bring every register, the irq and trigger outputs and the port oe pins back to zero
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK({irq1, irq2, irq, trg1, trg2, pb_e, pa_e}, 13'h0)
    for (i = 0; i < 10; i++)
      bus(1'b0, ADR[i], 0, 0, 1'b0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
